// ===== include/fbl_pkg.sv
// Shared constants and types for the flash block-lock host controller
package fbl_pkg;

  // ----------------------------------------
  // Software register map (APB, byte offsets)
  // ----------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ADDR = 8'h04;
  localparam logic [7:0] OFF_WDATA = 8'h08;
  localparam logic [7:0] OFF_RDATA = 8'h0c;
  localparam logic [7:0] OFF_STAT = 8'h10;
  localparam logic [7:0] OFF_PINCTL = 8'h14;

  // Field positions
  localparam int CTRL_START_BIT = 8;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_FLASH_LSB = 8;
  localparam int STAT_CMDERR_BIT = 16;
  localparam int PIN_WP_BIT = 0;
  localparam int PIN_RST_BIT = 1;

  // Reset values of the pin controls: protected and out of reset
  localparam logic RST_WP_N = 1'b0;
  localparam logic RST_FLASH_RST_N = 1'b1;

  // ----------------------------------------
  // Flash command codes and status bits
  // ----------------------------------------
  localparam logic [15:0] CMD_LOCK_SETUP = 16'h0060;
  localparam logic [15:0] CMD_LOCK_CONFIRM = 16'h0001;
  localparam logic [15:0] CMD_UNLOCK_CONFIRM = 16'h00d0;
  localparam logic [15:0] CMD_LOCKDOWN_CONFIRM = 16'h002f;
  localparam logic [15:0] CMD_READ_ID = 16'h0090;
  localparam logic [15:0] CMD_READ_ARRAY = 16'h00ff;
  localparam logic [15:0] CMD_READ_STATUS = 16'h0070;
  localparam logic [15:0] CMD_CLEAR_STATUS = 16'h0050;
  localparam logic [15:0] CMD_OTP_SETUP = 16'h00c0;
  localparam logic [15:0] CMD_SUSPEND = 16'h00b0;
  localparam logic [15:0] CMD_RESUME = 16'h00d0;
  localparam logic [15:0] OTP_LOCK_VALUE = 16'hfffd;
  localparam logic [1:0] LOCK_STATE_OFFSET = 2'h2;
  localparam int SR_LOCK_VIOLATION = 1;
  localparam int SR_SUPPLY_LOW = 3;
  localparam int SR_PROGRAM_FAIL = 4;
  localparam int SR_ERASE_FAIL = 5;
  localparam int SR_MACHINE_READY = 7;

  // ----------------------------------------
  // Bus timing at 25 MHz
  // ----------------------------------------
  localparam int CLK_MHZ = 25;
  localparam int T_SETUP_NS = 20;
  localparam int T_WR_PULSE_NS = 60;
  localparam int T_RD_ACCESS_NS = 90;
  localparam int T_HOLD_NS = 20;
  localparam int SETUP_CYC = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int WR_CYC = (T_WR_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int RD_CYC = (T_RD_ACCESS_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_CYC = (T_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int SYNC_CYC = 3;

  // ----------------------------------------
  // Operations and sequence steps
  // ----------------------------------------
  typedef enum logic [3:0] {
    OP_READ_ARRAY, OP_READ_STATUS, OP_CLEAR_STATUS, OP_LOCK, OP_UNLOCK,
    OP_LOCKDOWN, OP_LOCK_RAW, OP_READ_LOCK, OP_READ_ID, OP_OTP_PROG,
    OP_OTP_LOCK, OP_SUSPEND, OP_RESUME
  } fbl_op_t;

  typedef enum logic [1:0] {K_END, K_WR, K_RD, K_POLL} fbl_kind_t;

  typedef struct packed {
    fbl_kind_t kind;
    logic plus2;
    logic [15:0] data;
  } fbl_step_t;

endpackage : fbl_pkg

// ===== hw/fbl_cycle.sv
// One asynchronous flash bus cycle: write strobe or read with synchronised capture
module fbl_cycle #(
  parameter int ADDR_W = 22
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclk_en,
  input wire logic start,
  input wire logic is_read,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] dq_i,
  output logic done,
  output logic [15:0] rdata,
  output logic [ADDR_W-1:0] addr_o,
  output logic [15:0] dq_o,
  output logic dq_oe,
  output logic ce_n,
  output logic we_n,
  output logic oe_n
);

  typedef enum logic [1:0] {C_IDLE, C_SETUP, C_PULSE, C_HOLD} fbl_cyc_state_t;

  fbl_cyc_state_t state_reg;
  logic [3:0] cnt_reg;
  logic rd_reg;
  logic [15:0] dq_s1_reg;
  logic [15:0] dq_s2_reg;
  logic [15:0] dq_s3_reg;

  // ----------------------------------------
  // Pin input synchroniser
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dq_s1_reg <= 16'h0000;
      dq_s2_reg <= 16'h0000;
      dq_s3_reg <= 16'h0000;
    end
    else if (pclk_en)
    begin
      dq_s1_reg <= dq_i;
      dq_s2_reg <= dq_s1_reg;
      dq_s3_reg <= dq_s2_reg;
    end
  end

  // ----------------------------------------
  // Cycle sequencer
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= C_IDLE;
      cnt_reg <= 4'h0;
      rd_reg <= 1'b0;
      done <= 1'b0;
      rdata <= 16'h0000;
      addr_o <= '0;
      dq_o <= 16'h0000;
      dq_oe <= 1'b0;
      ce_n <= 1'b1;
      we_n <= 1'b1;
      oe_n <= 1'b1;
    end
    else if (pclk_en)
    begin
      done <= 1'b0;
      unique case (state_reg)
        C_IDLE:
        begin
          if (start)
          begin
            rd_reg <= is_read;
            addr_o <= addr;
            dq_o <= wdata;
            dq_oe <= !is_read;
            ce_n <= 1'b0;
            cnt_reg <= 4'(fbl_pkg::SETUP_CYC - 1);
            state_reg <= C_SETUP;
          end
        end
        C_SETUP:
        begin
          if (cnt_reg != 4'h0)
            cnt_reg <= cnt_reg - 4'h1;
          else
          begin
            we_n <= rd_reg;
            oe_n <= !rd_reg;
            // Read pulse also covers the pin synchroniser latency
            cnt_reg <= rd_reg ? 4'(fbl_pkg::RD_CYC + fbl_pkg::SYNC_CYC - 1)
                              : 4'(fbl_pkg::WR_CYC - 1);
            state_reg <= C_PULSE;
          end
        end
        C_PULSE:
        begin
          if (cnt_reg != 4'h0)
            cnt_reg <= cnt_reg - 4'h1;
          else if (!rd_reg || dq_s2_reg == dq_s3_reg)
          begin
            if (rd_reg)
              rdata <= dq_s3_reg;
            we_n <= 1'b1;
            oe_n <= 1'b1;
            cnt_reg <= 4'(fbl_pkg::HOLD_CYC - 1);
            state_reg <= C_HOLD;
          end
        end
        C_HOLD:
        begin
          if (cnt_reg != 4'h0)
            cnt_reg <= cnt_reg - 4'h1;
          else
          begin
            dq_oe <= 1'b0;
            ce_n <= 1'b1;
            done <= 1'b1;
            state_reg <= C_IDLE;
          end
        end
      endcase
    end
  end

endmodule : fbl_cycle

// ===== hw/fbl_host.sv
// Host controller for flash block locking and protection register, APB slave side
//
// Our own choice: register access over APB.
module fbl_host #(
  parameter int ADDR_W = 22
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [ADDR_W-1:0] flash_addr,
  output logic [15:0] flash_dq_o,
  output logic flash_dq_oe,
  input wire logic [15:0] flash_dq_i,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  output logic flash_wp_n,
  output logic flash_rst_n
);

  typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_WAIT} fbl_seq_state_t;

  fbl_seq_state_t state_reg;
  fbl_pkg::fbl_op_t op_reg;
  logic [2:0] step_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [15:0] wdata_reg;
  logic [15:0] rdata_reg;
  logic [7:0] flash_status_reg;
  logic done_reg;
  logic cyc_start;
  logic cyc_read;
  logic [ADDR_W-1:0] cyc_addr;
  logic [15:0] cyc_wdata;
  logic cyc_done;
  logic [15:0] cyc_rdata;
  logic [15:0] last_wdata_reg;
  fbl_pkg::fbl_step_t cur_step;
  logic wr_access;
  logic start_req;

  // ----------------------------------------
  // Sequence table
  // ----------------------------------------
  function automatic fbl_pkg::fbl_step_t mk(fbl_pkg::fbl_kind_t k, logic p2,
                                            logic [15:0] d);
    fbl_pkg::fbl_step_t s;
    s.kind = k;
    s.plus2 = p2;
    s.data = d;
    return s;
  endfunction : mk

  function automatic fbl_pkg::fbl_step_t step_of(fbl_pkg::fbl_op_t op, logic [2:0] i,
                                                 logic [15:0] wd);
    fbl_pkg::fbl_step_t s;
    s = mk(fbl_pkg::K_END, 1'b0, 16'h0000);
    unique case (op)
      fbl_pkg::OP_READ_ARRAY:
        if (i == 3'h0) s = mk(fbl_pkg::K_WR, 1'b0, fbl_pkg::CMD_READ_ARRAY);
      fbl_pkg::OP_READ_STATUS:
        if (i == 3'h0) s = mk(fbl_pkg::K_WR, 1'b0, fbl_pkg::CMD_READ_STATUS);
        else if (i == 3'h1) s = mk(fbl_pkg::K_POLL, 1'b0, 16'h0000);
      fbl_pkg::OP_CLEAR_STATUS:
        if (i == 3'h0) s = mk(fbl_pkg::K_WR, 1'b0, fbl_pkg::CMD_CLEAR_STATUS);
      fbl_pkg::OP_LOCK, fbl_pkg::OP_UNLOCK, fbl_pkg::OP_LOCKDOWN, fbl_pkg::OP_LOCK_RAW:
        if (i == 3'h0) s = mk(fbl_pkg::K_WR, 1'b0, fbl_pkg::CMD_LOCK_SETUP);
        else if (i == 3'h1)
          s = mk(fbl_pkg::K_WR, 1'b0,
                 op == fbl_pkg::OP_LOCK ? fbl_pkg::CMD_LOCK_CONFIRM :
                 op == fbl_pkg::OP_UNLOCK ? fbl_pkg::CMD_UNLOCK_CONFIRM :
                 op == fbl_pkg::OP_LOCKDOWN ? fbl_pkg::CMD_LOCKDOWN_CONFIRM : wd);
      fbl_pkg::OP_READ_LOCK, fbl_pkg::OP_READ_ID:
        if (i == 3'h0) s = mk(fbl_pkg::K_WR, 1'b0, fbl_pkg::CMD_READ_ID);
        else if (i == 3'h1) s = mk(fbl_pkg::K_RD, op == fbl_pkg::OP_READ_LOCK, 16'h0000);
        else if (i == 3'h2) s = mk(fbl_pkg::K_WR, 1'b0, fbl_pkg::CMD_READ_ARRAY);
      fbl_pkg::OP_OTP_PROG, fbl_pkg::OP_OTP_LOCK:
        if (i == 3'h0) s = mk(fbl_pkg::K_WR, 1'b0, fbl_pkg::CMD_OTP_SETUP);
        else if (i == 3'h1)
          s = mk(fbl_pkg::K_WR, 1'b0,
                 op == fbl_pkg::OP_OTP_LOCK ? fbl_pkg::OTP_LOCK_VALUE : wd);
        else if (i == 3'h2) s = mk(fbl_pkg::K_POLL, 1'b0, 16'h0000);
      fbl_pkg::OP_SUSPEND:
        if (i == 3'h0) s = mk(fbl_pkg::K_WR, 1'b0, fbl_pkg::CMD_SUSPEND);
        else if (i == 3'h1) s = mk(fbl_pkg::K_WR, 1'b0, fbl_pkg::CMD_READ_STATUS);
        else if (i == 3'h2) s = mk(fbl_pkg::K_POLL, 1'b0, 16'h0000);
      fbl_pkg::OP_RESUME:
        if (i == 3'h0) s = mk(fbl_pkg::K_WR, 1'b0, fbl_pkg::CMD_RESUME);
      default:
        s = mk(fbl_pkg::K_END, 1'b0, 16'h0000);
    endcase
    return s;
  endfunction : step_of

  assign cur_step = step_of(op_reg, step_reg, wdata_reg);
  assign cyc_read = cur_step.kind != fbl_pkg::K_WR;
  assign cyc_wdata = cur_step.data;
  // Lock state sits two words above the block base
  assign cyc_addr = cur_step.plus2 ? addr_reg + ADDR_W'(fbl_pkg::LOCK_STATE_OFFSET)
                                   : addr_reg;
  assign cyc_start = state_reg == S_ISSUE && cur_step.kind != fbl_pkg::K_END;

  // ----------------------------------------
  // APB slave: one wait state, write lands on the pready edge
  // ----------------------------------------
  assign wr_access = psel && penable && pready && pwrite;
  assign start_req = wr_access && paddr == fbl_pkg::OFF_CTRL &&
                     pwdata[fbl_pkg::CTRL_START_BIT];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else if (pclk_en)
    begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready)
      begin
        pslverr <= paddr > fbl_pkg::OFF_PINCTL || paddr[1:0] != 2'h0;
        prdata <= 32'h0000_0000;
        if (!pwrite)
        begin
          unique case (paddr)
            fbl_pkg::OFF_CTRL: prdata <= {28'h0000000, op_reg};
            fbl_pkg::OFF_ADDR: prdata <= 32'(addr_reg);
            fbl_pkg::OFF_WDATA: prdata <= {16'h0000, wdata_reg};
            fbl_pkg::OFF_RDATA: prdata <= {16'h0000, rdata_reg};
            fbl_pkg::OFF_STAT:
              prdata <= {15'h0000,
                         &{flash_status_reg[fbl_pkg::SR_PROGRAM_FAIL],
                           flash_status_reg[fbl_pkg::SR_ERASE_FAIL],
                           flash_status_reg[fbl_pkg::SR_MACHINE_READY]},
                         flash_status_reg, 6'h00, done_reg, state_reg != S_IDLE};
            fbl_pkg::OFF_PINCTL: prdata <= {30'h00000000, !flash_rst_n, flash_wp_n};
            default: prdata <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      addr_reg <= '0;
      wdata_reg <= 16'h0000;
      flash_wp_n <= fbl_pkg::RST_WP_N;
      flash_rst_n <= fbl_pkg::RST_FLASH_RST_N;
    end
    else if (pclk_en && wr_access)
    begin
      unique case (paddr)
        fbl_pkg::OFF_ADDR: addr_reg <= pwdata[ADDR_W-1:0];
        fbl_pkg::OFF_WDATA: wdata_reg <= pwdata[15:0];
        fbl_pkg::OFF_PINCTL:
        begin
          flash_wp_n <= pwdata[fbl_pkg::PIN_WP_BIT];
          flash_rst_n <= !pwdata[fbl_pkg::PIN_RST_BIT];
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Command sequencer
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= S_IDLE;
      op_reg <= fbl_pkg::OP_READ_ARRAY;
      step_reg <= 3'h0;
      done_reg <= 1'b0;
      rdata_reg <= 16'h0000;
      flash_status_reg <= 8'h00;
      last_wdata_reg <= 16'h0000;
    end
    else if (pclk_en)
    begin
      unique case (state_reg)
        S_IDLE:
        begin
          // Starts while busy are dropped; software checks the busy bit
          if (start_req)
          begin
            op_reg <= fbl_pkg::fbl_op_t'(pwdata[3:0]);
            step_reg <= 3'h0;
            done_reg <= 1'b0;
            state_reg <= S_ISSUE;
          end
        end
        S_ISSUE:
        begin
          if (cur_step.kind == fbl_pkg::K_END)
          begin
            done_reg <= 1'b1;
            state_reg <= S_IDLE;
          end
          else
          begin
            if (!cyc_read)
              last_wdata_reg <= cyc_wdata;
            state_reg <= S_WAIT;
          end
        end
        S_WAIT:
        begin
          if (cyc_done)
          begin
            state_reg <= S_ISSUE;
            if (cur_step.kind == fbl_pkg::K_RD)
              rdata_reg <= cyc_rdata;
            if (cur_step.kind == fbl_pkg::K_POLL)
              flash_status_reg <= cyc_rdata[7:0];
            // Error flags mean nothing until the machine reports ready
            if (cur_step.kind != fbl_pkg::K_POLL || cyc_rdata[fbl_pkg::SR_MACHINE_READY])
              step_reg <= step_reg + 3'h1;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  fbl_cycle #(.ADDR_W(ADDR_W)) u_cycle (
    .pclk(pclk),
    .presetn(presetn),
    .pclk_en(pclk_en),
    .start(cyc_start),
    .is_read(cyc_read),
    .addr(cyc_addr),
    .wdata(cyc_wdata),
    .dq_i(flash_dq_i),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .addr_o(flash_addr),
    .dq_o(flash_dq_o),
    .dq_oe(flash_dq_oe),
    .ce_n(flash_ce_n),
    .we_n(flash_we_n),
    .oe_n(flash_oe_n)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_wr(logic [15:0] d);
    cyc_start && !cyc_read && cyc_wdata == d;
  endsequence

  sequence s_confirm(fbl_pkg::fbl_op_t op);
    cyc_start && op_reg == op && step_reg == 3'h1;
  endsequence

  AST_LOCK_PAIR: assert property (s_confirm(fbl_pkg::OP_LOCK) |->
    cyc_wdata == fbl_pkg::CMD_LOCK_CONFIRM && last_wdata_reg == fbl_pkg::CMD_LOCK_SETUP)
    else $error("lock confirm not preceded by setup");
  AST_UNLOCK_PAIR: assert property (s_confirm(fbl_pkg::OP_UNLOCK) |->
    cyc_wdata == fbl_pkg::CMD_UNLOCK_CONFIRM && last_wdata_reg == fbl_pkg::CMD_LOCK_SETUP)
    else $error("unlock confirm wrong");
  AST_LOCKDOWN_NEXT: assert property (
    (s_wr(fbl_pkg::CMD_LOCK_SETUP) and (op_reg == fbl_pkg::OP_LOCKDOWN)) |->
    ##[1:40] s_wr(fbl_pkg::CMD_LOCKDOWN_CONFIRM))
    else $error("lock-down confirm missing");
  AST_LOCK_STATE_ADDR: assert property (
    (cyc_start && op_reg == fbl_pkg::OP_READ_LOCK && step_reg == 3'h1) |->
    cyc_read && cyc_addr == addr_reg + ADDR_W'(fbl_pkg::LOCK_STATE_OFFSET) &&
    last_wdata_reg == fbl_pkg::CMD_READ_ID)
    else $error("lock state read misplaced");
  AST_SUSPEND_POLL: assert property (
    (state_reg == S_WAIT && op_reg == fbl_pkg::OP_SUSPEND && step_reg == 3'h2 &&
     cyc_done && !cyc_rdata[fbl_pkg::SR_MACHINE_READY]) |=>
    state_reg == S_ISSUE && step_reg == 3'h2)
    else $error("suspend left before ready");
  AST_ID_EXIT: assert property (
    (cyc_done && state_reg == S_WAIT && op_reg == fbl_pkg::OP_READ_ID && step_reg == 3'h1)
    |-> ##[1:40] s_wr(fbl_pkg::CMD_READ_ARRAY))
    else $error("identifier mode not left");
  AST_OTP_PAIR: assert property (
    s_confirm(fbl_pkg::OP_OTP_PROG) |->
    cyc_wdata == wdata_reg && last_wdata_reg == fbl_pkg::CMD_OTP_SETUP && !cyc_read)
    else $error("protection program pair wrong");
  AST_OTP_LOCK_VALUE: assert property (
    s_confirm(fbl_pkg::OP_OTP_LOCK) |-> cyc_wdata == fbl_pkg::OTP_LOCK_VALUE &&
    cyc_addr == addr_reg)
    else $error("segment lock value wrong");

endmodule : fbl_host

// ===== verif/fbl_flash_model.sv
// Behavioural flash device: block locks, protection register and status
module fbl_flash_model #(
  parameter int ADDR_W = 22,
  parameter logic [21:0] OTP_LOCKW = 22'h000080
) (
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic wp_n,
  input wire logic rst_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // Power-up state: every block locked, nothing locked down
  logic [127:0] lk = '1;
  logic [127:0] ld = '0;
  logic [7:0] sr = 8'h80;
  logic [2:0] mode = 3'd0;
  // Busy for two status reads after suspend or protection program
  logic [1:0] busy_cnt = 2'd0;
  logic [15:0] otp_lw = 16'hfffe;
  logic [15:0] last = 16'h0000;
  logic [15:0] rd;
  logic [6:0] b;
  assign b = addr[ADDR_W-1:ADDR_W-7];
  // ----------------------------------------
  // Command decode on the write strobe
  // ----------------------------------------
  always @(negedge rst_n)
  begin
    lk = '1;
    ld = '0;
    sr = 8'h80;
    mode = 3'd0;
    busy_cnt = 2'd0;
  end
  // Dropping protect re-arms every block locked down since the last flash reset
  always @(negedge wp_n)
    lk = lk | ld;
  always @(posedge we_n)
  begin
    if (rst_n && !ce_n)
    begin
      if (mode == 3'd3)
      begin
        if (dq_in == 16'h0001) lk[b] = 1'b1;
        else if (dq_in == 16'h00d0 && (wp_n || !ld[b])) lk[b] = 1'b0;
        else if (dq_in == 16'h002f) {ld[b], lk[b]} = 2'b11;
        else if (dq_in != 16'h00d0) sr[5:4] = 2'b11;
        mode = 3'd1;
      end
      else if (mode == 3'd4)
      begin
        if (!otp_lw[1]) {sr[4], sr[1]} = 2'b11;
        else if (addr == OTP_LOCKW) otp_lw = otp_lw & dq_in;
        busy_cnt = 2'd2;
        mode = 3'd1;
      end
      else
        case (dq_in)
          16'h0060: mode = 3'd3;
          16'h00c0: mode = 3'd4;
          16'h0090: mode = 3'd2;
          16'h00ff: mode = 3'd0;
          16'h0070: mode = 3'd1;
          16'h0050: sr[5:1] = 5'h00;
          16'h00b0:
          begin
            {sr[6], mode} = {1'b1, 3'd1};
            busy_cnt = 2'd2;
          end
          // Resume leaves a pending command error standing
          16'h00d0: sr[6] = 1'b0;
          default: ;
        endcase
    end
  end
  // ----------------------------------------
  // Read path
  // ----------------------------------------
  always_comb
    if (mode == 3'd1) rd = {8'h00, sr[7] && busy_cnt == 2'd0, sr[6:0]};
    else if (mode == 3'd2 && addr == OTP_LOCKW) rd = otp_lw;
    else if (mode == 3'd2 && addr[14:0] == 15'h0002) rd = {14'h0000, ld[b], lk[b]};
    else rd = 16'h0000;
  // Undriven bus shows the inverse of the last word, never a held value
  assign dq_out = (!ce_n && !oe_n) ? rd : ~last;
  always @(posedge oe_n)
  begin
    last = rd;
    if (busy_cnt != 2'd0 && mode == 3'd1) busy_cnt = busy_cnt - 2'd1;
  end
endmodule : fbl_flash_model

// ===== verif/testbench.sv
// Self-checking bench for the block-lock host controller
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {fbl_pkg::fbl_op_t op; logic [6:0] blk; logic wp; logic [1:0] exp;} fbl_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [21:0] f_addr;
  logic [15:0] f_dq_o, f_dq_i;
  logic f_oe, f_ce_n, f_we_n, f_oe_n, f_wp_n, f_rst_n;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  fbl_row_t rows [9] = '{
    '{fbl_pkg::OP_READ_LOCK, 7'd0, 1'b0, 2'b01}, '{fbl_pkg::OP_UNLOCK, 7'd0, 1'b0, 2'b00},
    '{fbl_pkg::OP_LOCK, 7'd0, 1'b0, 2'b01}, '{fbl_pkg::OP_LOCKDOWN, 7'd1, 1'b0, 2'b11},
    '{fbl_pkg::OP_UNLOCK, 7'd1, 1'b0, 2'b11}, '{fbl_pkg::OP_UNLOCK, 7'd1, 1'b1, 2'b10},
    '{fbl_pkg::OP_LOCK, 7'd1, 1'b1, 2'b11}, '{fbl_pkg::OP_UNLOCK, 7'd1, 1'b1, 2'b10},
    '{fbl_pkg::OP_READ_LOCK, 7'd1, 1'b0, 2'b11}};
  localparam logic [21:0] USER_W = 22'h000085;
  localparam logic [21:0] LOCK_W = 22'h000080;
  fbl_host i_dut (.pclk(pclk), .presetn(presetn), .pclk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .flash_addr(f_addr), .flash_dq_o(f_dq_o),
    .flash_dq_oe(f_oe), .flash_dq_i(f_dq_i), .flash_ce_n(f_ce_n), .flash_we_n(f_we_n),
    .flash_oe_n(f_oe_n), .flash_wp_n(f_wp_n), .flash_rst_n(f_rst_n));
  fbl_flash_model i_flash (.addr(f_addr), .dq_in(f_dq_o), .dq_out(f_dq_i), .ce_n(f_ce_n),
    .we_n(f_we_n), .oe_n(f_oe_n), .wp_n(f_wp_n), .rst_n(f_rst_n));
  // ----------------------------------------
  // Clock, timeout and helpers
  // ----------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task wrap_up();
    $display("mismatches %0d comparisons %0d", fail_count, compares);
    if (fail_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up
  // Generous ceiling: the whole run needs under two thousand cycles
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      wrap_up();
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      fail_count++;
      $display("MISMATCH at %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  // Host drives data across every write strobe and releases it for reads
  always @(posedge f_we_n)
    if (presetn && f_oe !== 1'b1)
    begin
      fail_count++;
      $display("MISMATCH at %0t data released at write strobe", $time);
    end
  always @(negedge f_oe_n)
    if (presetn && f_oe !== 1'b0)
    begin
      fail_count++;
      $display("MISMATCH at %0t data driven during read", $time);
    end
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    // Answer is taken at the very edge that sees pready high
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task run_op(input fbl_pkg::fbl_op_t op, input logic [21:0] a, input logic [15:0] d);
    apb(1'b1, fbl_pkg::OFF_ADDR, {10'h000, a});
    apb(1'b1, fbl_pkg::OFF_WDATA, {16'h0000, d});
    apb(1'b1, fbl_pkg::OFF_CTRL, (32'h1 << fbl_pkg::CTRL_START_BIT) | {28'h0, op});
    do apb(1'b0, fbl_pkg::OFF_STAT, 32'h0); while (rd[fbl_pkg::STAT_DONE_BIT] !== 1'b1);
  endtask : run_op
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, fbl_pkg::OFF_PINCTL, 32'h0);
    chk(rd, 32'h0);
    foreach (rows[i])
    begin
      apb(1'b1, fbl_pkg::OFF_PINCTL, {31'h0, rows[i].wp});
      run_op(rows[i].op, {rows[i].blk, 15'h0000}, 16'h0000);
      run_op(fbl_pkg::OP_READ_LOCK, {rows[i].blk, 15'h0000}, 16'h0000);
      apb(1'b0, fbl_pkg::OFF_RDATA, 32'h0);
      chk(rd[1:0], rows[i].exp);
    end
    run_op(fbl_pkg::OP_SUSPEND, 22'h0, 16'h0000);
    chk(rd[15:14], 2'b11);
    run_op(fbl_pkg::OP_UNLOCK, 22'h0, 16'h0000);
    run_op(fbl_pkg::OP_READ_LOCK, 22'h0, 16'h0000);
    apb(1'b0, fbl_pkg::OFF_RDATA, 32'h0);
    chk(rd[1:0], 2'b00);
    run_op(fbl_pkg::OP_LOCK_RAW, 22'h0, 16'h0033);
    run_op(fbl_pkg::OP_RESUME, 22'h0, 16'h0000);
    run_op(fbl_pkg::OP_READ_STATUS, 22'h0, 16'h0000);
    chk({rd[fbl_pkg::STAT_CMDERR_BIT], rd[13:12]}, 3'b111);
    run_op(fbl_pkg::OP_CLEAR_STATUS, 22'h0, 16'h0000);
    run_op(fbl_pkg::OP_OTP_PROG, USER_W, 16'h1234);
    chk({rd[12], rd[9]}, 2'b00);
    run_op(fbl_pkg::OP_OTP_LOCK, LOCK_W, 16'h0000);
    run_op(fbl_pkg::OP_OTP_PROG, USER_W, 16'h5678);
    chk({rd[12], rd[9]}, 2'b11);
    run_op(fbl_pkg::OP_READ_ID, LOCK_W, 16'h0000);
    apb(1'b0, fbl_pkg::OFF_RDATA, 32'h0);
    chk(rd[15:0], 16'hfffc);
    apb(1'b1, fbl_pkg::OFF_PINCTL, 32'h2);
    @(negedge pclk);
    chk(f_rst_n, 1'b0);
    apb(1'b1, fbl_pkg::OFF_PINCTL, 32'h0);
    run_op(fbl_pkg::OP_READ_LOCK, {7'd1, 15'h0000}, 16'h0000);
    apb(1'b0, fbl_pkg::OFF_RDATA, 32'h0);
    chk(rd[1:0], 2'b01);
    apb(1'b0, 8'h18, 32'h0);
    chk({er, rd[30:0]}, 32'h80000000);
    wrap_up();
  end
endmodule : testbench
